// *** rtl/qpc_defines.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef QPC_DEFINES_SVH
`define QPC_DEFINES_SVH
// Operation
// - Phase B comes from a selectable line; selecting none halts the counter.
// - Filtered mode changes the count by one per complete quadrature cycle.
// - Unfiltered mode changes the count on every single phase transition.
// - One output pulse per programmed number of steps; divide value above zero.
// - Output selector disabled means no output pulses at all.
// - Forward new-place mode pulses only beyond the furthest forward position.
// - Backward new-place mode pulses only beyond the furthest backward position.
// - Forward steps mode pulses on every up step, ignoring down motion.
// - Backward steps mode pulses on every down step, ignoring up motion.
// - Any-motion mode pulses on every step in either direction.
// - Status shows last step up, last step down, or unit inactive.
// - Status turns static when no step occurs within the timeout in us.
// - Hardware clear source selectable from many event groups, or disabled.
// - Selected clear source captures the pre-clear count before clearing.
// - Edge sense clears on rising, falling or both edges of the source.
// - Level sense holds the count clear while the source is high or low.
// - Software clear command clears, counts on at once, and captures.
// - Position count is readable and writable; a write loads a start value.
// - Captured value keeps the latest pre-clear count until the next clear.
// - Phase A comes from a selectable line; selecting none halts the counter.
// - Filtered mode: leaving 00 sets direction; entering 00 counts by it.
// - Transitions changing both phase bits at once are ignored as illegal.
// - Count wraps between maximum and minimum; both limits readable.

`define QPC_CTRL_OFS     8'h00
`define QPC_SRC_OFS      8'h04
`define QPC_DIV_OFS      8'h08
`define QPC_TMO_OFS      8'h0c
`define QPC_CMD_OFS      8'h10
`define QPC_POS_OFS      8'h14
`define QPC_CAP_OFS      8'h18
`define QPC_STAT_OFS     8'h1c
`define QPC_MAX_OFS      8'h20
`define QPC_MIN_OFS      8'h24

// Control fields
`define QPC_CTRL_RES_BIT 0
`define QPC_CTRL_OUT_LSB 4
`define QPC_CTRL_SNS_LSB 8

// Source select: 0 = none, n = line n-1
`define QPC_SRC_A_LSB    0
`define QPC_SRC_B_LSB    8
`define QPC_SRC_CLR_LSB  16

`define QPC_NLINES       8
`define QPC_NCLR         64
`define QPC_DIV_RST      16'h0001
`define QPC_TMO_RST      32'h0000_03e8
`define QPC_CLK_MHZ      40
`define QPC_POS_MAX      32'h7fff_ffff
`define QPC_POS_MIN      32'h8000_0000
`endif

// *** rtl/qpc_pkg.sv ***
// Types for the quadrature position counter
package qpc_pkg;
    typedef enum logic [2:0] {
        QPC_OUT_OFF, QPC_FWD_NEW_PLACE, QPC_BACK_NEW_PLACE,
        QPC_FWD_STEPS_ONLY, QPC_BACK_STEPS_ONLY, QPC_ANY_MOTION
    } qpc_out_mode_t;
    typedef enum logic [2:0] {
        QPC_SENSE_RISE, QPC_SENSE_FALL, QPC_SENSE_BOTH_EDGES,
        QPC_SENSE_HOLD_HIGH, QPC_SENSE_HOLD_LOW
    } qpc_sense_t;
    typedef enum logic [1:0] {
        QPC_UNIT_INACTIVE, QPC_LAST_STEP_INCREMENT,
        QPC_LAST_STEP_DECREMENT, QPC_NO_MOTION_TIMED_OUT
    } qpc_motion_t;
endpackage : qpc_pkg

// *** rtl/qpc_step_decode.sv ***
// Quadrature phase decoder producing up and down step strobes
`timescale 1ns/1ps
`default_nettype none
module qpc_step_decode
    import qpc_pkg::*;
(
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Phases and mode
    input  wire logic       enable,
    input  wire logic       filtered_full_cycle,
    input  wire logic [1:0] phase,
    // Steps
    output logic            step_up,
    output logic            step_dn
);
    logic [1:0] prev_q;
    logic       dir_pos_q;
    logic       seen_q;
    logic [1:0] gray_prev;
    logic [1:0] gray_cur;
    logic [1:0] diff;
    wire        changed = enable && seen_q && (phase != prev_q);
    wire        legal   = (phase ^ prev_q) != 2'b11;
    wire        fwd;
    wire        enter0  = phase == 2'b00;
    wire        leave0  = prev_q == 2'b00;

    // Gray order 00,01,11,10 maps to 0..3
    assign gray_prev = {prev_q[1], prev_q[1] ^ prev_q[0]};
    assign gray_cur  = {phase[1], phase[1] ^ phase[0]};
    assign diff      = gray_cur - gray_prev;
    assign fwd       = diff == 2'b01;

    // Per phase when unfiltered, only on entering 00 when filtered
    // Jitter back into 00 moves against the flag, so it never counts
    assign step_up = changed && legal && (filtered_full_cycle
                     ? (enter0 && dir_pos_q && fwd)
                     : fwd);
    assign step_dn = changed && legal && (filtered_full_cycle
                     ? (enter0 && !dir_pos_q && !fwd)
                     : !fwd);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_q    <= 2'b00;
            dir_pos_q <= 1'b1;
            seen_q    <= 1'b0;
        end else if (!enable) begin
            // Forget the old phase so re-enabling cannot fake a step
            seen_q <= 1'b0;
        end else begin
            seen_q <= 1'b1;
            if (!seen_q || legal)
                prev_q <= phase;
            if (changed && legal && leave0)
                dir_pos_q <= fwd;
        end
    end
endmodule : qpc_step_decode
`default_nettype wire

// *** rtl/qpc_top.sv ***
// AHB-Lite quadrature position counter with pulse output and status
`timescale 1ns/1ps
`default_nettype none
`include "qpc_defines.svh"
module qpc_top (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // I/O lines and clear sources
    input  wire logic [7:0]  io_lines,
    input  wire logic [63:0] clear_sources,
    // Encoder output pulse and status
    output logic             pulse_out,
    output qpc_pkg::qpc_motion_t motion_state
);
    import qpc_pkg::*;

    localparam int TICKS_PER_US = `QPC_CLK_MHZ;

    // Registers
    logic          count_resolution_select_q;
    qpc_out_mode_t pulse_generation_select_q;
    qpc_sense_t    clear_trigger_sense_q;
    logic [3:0]    phase_a_input_select_q;
    logic [3:0]    phase_b_input_select_q;
    logic [6:0]    clear_trigger_select_q;
    logic [15:0]   pulse_divide_count_q;
    logic [31:0]   inactivity_limit_q;
    logic [31:0]   position_count_q;
    logic [31:0]   count_captured_on_clear_q;
    qpc_motion_t   motion_q;
    logic [15:0]   div_cnt_q;
    logic [31:0]   hi_mark_q;
    logic [31:0]   lo_mark_q;
    logic [5:0]    us_tick_q;
    logic [31:0]   idle_us_q;
    logic          clr_src_q;
    logic          pulse_q;
    logic [31:0]   rdata_q;
    // Bus data phase
    logic          wr_pend_q;
    logic [7:0]    wr_addr_q;

    // Phase selection; no source stops counting
    wire  a_on = phase_a_input_select_q != 4'h0;
    wire  b_on = phase_b_input_select_q != 4'h0;
    wire  [2:0] a_idx = 3'(phase_a_input_select_q - 4'h1);
    wire  [2:0] b_idx = 3'(phase_b_input_select_q - 4'h1);
    wire  [1:0] phase = {io_lines[a_idx], io_lines[b_idx]};
    logic step_up;
    logic step_dn;

    qpc_step_decode u_dec (
        .hclk                (hclk),
        .hresetn             (hresetn),
        .enable              (a_on && b_on),
        .filtered_full_cycle (!count_resolution_select_q),
        .phase               (phase),
        .step_up             (step_up),
        .step_dn             (step_dn)
    );

    // Hardware clear source and sense
    wire  src_on  = clear_trigger_select_q != 7'h00;
    wire  [5:0] s_idx = 6'(clear_trigger_select_q - 7'h01);
    wire  src_lvl = src_on && clear_sources[s_idx];
    logic hw_clear;
    always_comb begin
        hw_clear = 1'b0;
        case (clear_trigger_sense_q)
            QPC_SENSE_RISE:       hw_clear = src_lvl && !clr_src_q;
            QPC_SENSE_FALL:       hw_clear = src_on && !src_lvl && clr_src_q;
            QPC_SENSE_BOTH_EDGES: hw_clear = src_lvl != clr_src_q;
            QPC_SENSE_HOLD_HIGH:  hw_clear = src_lvl;
            QPC_SENSE_HOLD_LOW:   hw_clear = src_on && !src_lvl;
            default:              hw_clear = 1'b0;
        endcase
    end

    // Bus decode
    wire  addr_ok  = hsel && htrans[1] && hready;
    wire  wr_now   = addr_ok && hwrite;
    wire  rd_now   = addr_ok && !hwrite;
    wire  do_wr    = wr_pend_q;
    wire  sw_clear = do_wr && wr_addr_q == `QPC_CMD_OFS && hwdata[0];
    wire  pos_wr   = do_wr && wr_addr_q == `QPC_POS_OFS;
    wire  any_clr  = hw_clear || sw_clear;
    wire  step     = step_up || step_dn;

    // Wrap is natural two's complement overflow between the limits
    wire  [31:0] pos_next = step_up ? position_count_q + 32'h1 :
                             step_dn ? position_count_q - 32'h1 :
                             position_count_q;
    // New place tracking: hi/lo marks remember furthest reach
    wire  new_hi = step_up && ($signed(pos_next) > $signed(hi_mark_q));
    wire  new_lo = step_dn && ($signed(pos_next) < $signed(lo_mark_q));
    logic qual;
    always_comb begin
        case (pulse_generation_select_q)
            QPC_FWD_NEW_PLACE:   qual = new_hi;
            QPC_BACK_NEW_PLACE:  qual = new_lo;
            QPC_FWD_STEPS_ONLY:  qual = step_up;
            QPC_BACK_STEPS_ONLY: qual = step_dn;
            QPC_ANY_MOTION:      qual = step;
            default:             qual = 1'b0;
        endcase
    end
    wire  div_hit = qual && (div_cnt_q + 16'h1 >= pulse_divide_count_q);

    // Configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_resolution_select_q <= 1'b0;
            pulse_generation_select_q <= QPC_OUT_OFF;
            clear_trigger_sense_q     <= QPC_SENSE_RISE;
            phase_a_input_select_q    <= 4'h0;
            phase_b_input_select_q    <= 4'h0;
            clear_trigger_select_q    <= 7'h00;
            pulse_divide_count_q      <= `QPC_DIV_RST;
            inactivity_limit_q        <= `QPC_TMO_RST;
        end else if (do_wr) begin
            case (wr_addr_q)
                `QPC_CTRL_OFS: begin
                    count_resolution_select_q <= hwdata[`QPC_CTRL_RES_BIT];
                    pulse_generation_select_q <= qpc_out_mode_t'(
                        hwdata[`QPC_CTRL_OUT_LSB +: 3]);
                    clear_trigger_sense_q <= qpc_sense_t'(
                        hwdata[`QPC_CTRL_SNS_LSB +: 3]);
                end
                `QPC_SRC_OFS: begin
                    phase_a_input_select_q <= hwdata[`QPC_SRC_A_LSB +: 4];
                    phase_b_input_select_q <= hwdata[`QPC_SRC_B_LSB +: 4];
                    clear_trigger_select_q <= hwdata[`QPC_SRC_CLR_LSB +: 7];
                end
                `QPC_DIV_OFS:
                    if (hwdata[15:0] != 16'h0)
                        pulse_divide_count_q <= hwdata[15:0];
                `QPC_TMO_OFS:
                    if (hwdata != 32'h0)
                        inactivity_limit_q <= hwdata;
                default: ;
            endcase
        end
    end

    // Counter, capture and output pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            position_count_q          <= 32'h0;
            count_captured_on_clear_q <= 32'h0;
            hi_mark_q                 <= 32'h0;
            lo_mark_q                 <= 32'h0;
            div_cnt_q                 <= 16'h0;
            pulse_q                   <= 1'b0;
            clr_src_q                 <= 1'b0;
        end else begin
            clr_src_q <= src_lvl;
            pulse_q   <= 1'b0;
            if (any_clr) begin
                // Hold levels recapture each cycle; value stays zero
                count_captured_on_clear_q <= position_count_q;
                position_count_q <= 32'h0;
                hi_mark_q        <= 32'h0;
                lo_mark_q        <= 32'h0;
                div_cnt_q        <= 16'h0;
            end else if (pos_wr) begin
                position_count_q <= hwdata;
                hi_mark_q        <= hwdata;
                lo_mark_q        <= hwdata;
            end else begin
                position_count_q <= pos_next;
                if (new_hi)
                    hi_mark_q <= pos_next;
                if (new_lo)
                    lo_mark_q <= pos_next;
                if (div_hit) begin
                    div_cnt_q <= 16'h0;
                    pulse_q   <= 1'b1;
                end else if (qual)
                    div_cnt_q <= div_cnt_q + 16'h1;
            end
        end
    end

    // Motion status with microsecond inactivity timer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            motion_q  <= QPC_UNIT_INACTIVE;
            us_tick_q <= 6'h0;
            idle_us_q <= 32'h0;
        end else if (!(a_on && b_on)) begin
            motion_q  <= QPC_UNIT_INACTIVE;
            us_tick_q <= 6'h0;
            idle_us_q <= 32'h0;
        end else if (step) begin
            motion_q  <= step_up ? QPC_LAST_STEP_INCREMENT
                                 : QPC_LAST_STEP_DECREMENT;
            us_tick_q <= 6'h0;
            idle_us_q <= 32'h0;
        end else if (us_tick_q == 6'(TICKS_PER_US - 1)) begin
            us_tick_q <= 6'h0;
            if (idle_us_q + 32'h1 >= inactivity_limit_q &&
                motion_q != QPC_UNIT_INACTIVE)
                motion_q <= QPC_NO_MOTION_TIMED_OUT;
            if (idle_us_q != 32'hffff_ffff)
                idle_us_q <= idle_us_q + 32'h1;
        end else begin
            us_tick_q <= us_tick_q + 6'h1;
        end
    end

    // Read mux
    logic [31:0] rd_mux;
    always_comb begin
        case (haddr)
            `QPC_CTRL_OFS: rd_mux = {21'h0, clear_trigger_sense_q, 1'b0,
                                     pulse_generation_select_q, 3'h0,
                                     count_resolution_select_q};
            `QPC_SRC_OFS:  rd_mux = {9'h0, clear_trigger_select_q, 4'h0,
                                     phase_b_input_select_q, 4'h0,
                                     phase_a_input_select_q};
            `QPC_DIV_OFS:  rd_mux = {16'h0, pulse_divide_count_q};
            `QPC_TMO_OFS:  rd_mux = inactivity_limit_q;
            `QPC_POS_OFS:  rd_mux = position_count_q;
            `QPC_CAP_OFS:  rd_mux = count_captured_on_clear_q;
            `QPC_STAT_OFS: rd_mux = {30'h0, motion_q};
            `QPC_MAX_OFS:  rd_mux = `QPC_POS_MAX;
            `QPC_MIN_OFS:  rd_mux = `QPC_POS_MIN;
            default:       rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h0;
            rdata_q   <= 32'h0;
        end else begin
            wr_pend_q <= wr_now;
            if (wr_now)
                wr_addr_q <= haddr;
            if (rd_now)
                rdata_q <= rd_mux;
        end
    end

    assign hrdata       = rdata_q;
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign pulse_out    = pulse_q;
    assign motion_state = motion_q;

    // Checks
    property p_off_silent;
        @(posedge hclk) disable iff (!hresetn)
        pulse_generation_select_q == QPC_OUT_OFF |=> !pulse_q;
    endproperty
    a_off_silent: assert property (p_off_silent)
        else $error("pulse while output disabled");

    property p_halt;
        @(posedge hclk) disable iff (!hresetn)
        !a_on |-> !step;
    endproperty
    a_halt: assert property (p_halt)
        else $error("step with phase A unselected");

    property p_halt_b;
        @(posedge hclk) disable iff (!hresetn)
        !b_on |-> !step;
    endproperty
    a_halt_b: assert property (p_halt_b)
        else $error("step with phase B unselected");

    property p_clear;
        @(posedge hclk) disable iff (!hresetn)
        any_clr |=> position_count_q == 32'h0 &&
                    count_captured_on_clear_q == $past(position_count_q);
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not capture and zero");

    property p_sw_clear;
        @(posedge hclk) disable iff (!hresetn)
        sw_clear |=> hi_mark_q == 32'h0;
    endproperty
    a_sw_clear: assert property (p_sw_clear)
        else $error("software clear missed tracking state");

    property p_up;
        @(posedge hclk) disable iff (!hresetn)
        step_up && !any_clr && !pos_wr |=>
            position_count_q == $past(position_count_q) + 32'h1;
    endproperty
    a_up: assert property (p_up)
        else $error("increment lost");

    property p_dn;
        @(posedge hclk) disable iff (!hresetn)
        step_dn && !any_clr && !pos_wr |=>
            position_count_q == $past(position_count_q) - 32'h1;
    endproperty
    a_dn: assert property (p_dn)
        else $error("decrement lost");

    property p_fwd_only;
        @(posedge hclk) disable iff (!hresetn)
        pulse_generation_select_q == QPC_FWD_STEPS_ONLY && !step_up
            |=> !pulse_q;
    endproperty
    a_fwd_only: assert property (p_fwd_only)
        else $error("pulse without up step");

    property p_back_only;
        @(posedge hclk) disable iff (!hresetn)
        pulse_generation_select_q == QPC_BACK_STEPS_ONLY && !step_dn
            |=> !pulse_q;
    endproperty
    a_back_only: assert property (p_back_only)
        else $error("pulse without down step");

    property p_status;
        @(posedge hclk) disable iff (!hresetn)
        step_dn && a_on && b_on |=> motion_q == QPC_LAST_STEP_DECREMENT;
    endproperty
    a_status: assert property (p_status)
        else $error("status not decrement");

    property p_write;
        @(posedge hclk) disable iff (!hresetn)
        pos_wr && !any_clr |=> position_count_q == $past(hwdata);
    endproperty
    a_write: assert property (p_write)
        else $error("position write not loaded");
endmodule : qpc_top
`default_nettype wire

// *** dv/qpc_encoder_model.sv ***
// Behavioural quadrature encoder driving the two phase lines
`timescale 1ns/1ps
`default_nettype none
module qpc_encoder_model (
    // Clock
    input  wire logic hclk,
    // Phase outputs
    output logic      phase_a,
    output logic      phase_b
);
    logic [1:0] idx_q = 2'h0;

    // Gray order 00,01,11,10 as {a,b}; lines hold still between moves
    assign phase_a = idx_q[1];
    assign phase_b = idx_q[1] ^ idx_q[0];

    // Step 1 goes up, 3 goes down, 2 jumps two states at once
    task automatic move(logic [1:0] step, int n);
        repeat (n) begin
            @(posedge hclk);
            idx_q <= idx_q + step;
            repeat (3) @(posedge hclk);
        end
    endtask
endmodule // qpc_encoder_model
`default_nettype wire

// *** dv/qpc_bench.sv ***
// Self-checking bench for the quadrature position counter
`timescale 1ns/1ps
`default_nettype none
`include "qpc_defines.svh"
module qpc_bench;
    import qpc_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] hwdata = 32'h0;
    logic [63:0] clear_sources = 64'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        pulse_out;
    logic        phase_a;
    logic        phase_b;
    qpc_motion_t motion_state;
    int          errors = 0;
    int          total_checks = 0;
    int          pulses = 0;

    always #12.5 hclk = ~hclk;
    always @(posedge hclk) if (pulse_out === 1'b1) pulses++;

    // The slave's hreadyout is the bus's hready
    qpc_top dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .io_lines({6'h00, phase_b, phase_a}),
        .clear_sources(clear_sources), .pulse_out(pulse_out),
        .motion_state(motion_state)
    );
    qpc_encoder_model enc_u (.hclk(hclk), .phase_a(phase_a),
                             .phase_b(phase_b));

    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic idle(int n);
        repeat (n) @(posedge hclk);
    endtask

    // One single word transfer; read data taken at the data phase edge
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d,
                       output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rc(logic [7:0] a, logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk($sformatf("reg %h", a), q, e);
        chk("hresp", hresp, 32'h0);
    endtask

    task automatic t_reset();
        chk("state", motion_state, QPC_UNIT_INACTIVE);
        rc(`QPC_DIV_OFS, 32'h1);
        rc(`QPC_TMO_OFS, `QPC_TMO_RST);
        rc(`QPC_MAX_OFS, `QPC_POS_MAX);
        rc(`QPC_MIN_OFS, `QPC_POS_MIN);
        rc(8'h28, 32'h0);
        enc_u.move(2'h1, 4);
        rc(`QPC_POS_OFS, 32'h0);
        wr(`QPC_SRC_OFS, 32'h1);
        enc_u.move(2'h1, 4);
        rc(`QPC_POS_OFS, 32'h0);
        wr(`QPC_SRC_OFS, 32'h200);
        enc_u.move(2'h1, 4);
        rc(`QPC_POS_OFS, 32'h0);
    endtask

    task automatic t_filtered();
        wr(`QPC_SRC_OFS, 32'h201);
        wr(`QPC_CTRL_OFS, 32'h50);
        pulses = 0;
        enc_u.move(2'h1, 4);
        rc(`QPC_POS_OFS, 32'h1);
        chk("state", motion_state, QPC_LAST_STEP_INCREMENT);
        // Jitter between 01 and 11 inside one full cycle
        enc_u.move(2'h1, 2);
        enc_u.move(2'h3, 1);
        enc_u.move(2'h1, 3);
        rc(`QPC_POS_OFS, 32'h2);
        enc_u.move(2'h2, 2);
        rc(`QPC_POS_OFS, 32'h2);
        enc_u.move(2'h3, 4);
        rc(`QPC_POS_OFS, 32'h1);
        chk("state", motion_state, QPC_LAST_STEP_DECREMENT);
        chk("pulses", pulses, 3);
    endtask

    task automatic t_modes();
        int exp_p[6] = '{0, 2, 1, 5, 3, 8};
        for (int m = 0; m < 6; m++) begin
            wr(`QPC_CTRL_OFS, 32'h1 | (m << 4));
            wr(`QPC_CMD_OFS, 32'h1);
            pulses = 0;
            enc_u.move(2'h1, 2);
            enc_u.move(2'h3, 3);
            enc_u.move(2'h1, 3);
            chk("pulses", pulses, exp_p[m]);
            rc(`QPC_POS_OFS, 32'h2);
        end
    endtask

    task automatic t_divide();
        wr(`QPC_DIV_OFS, 32'h3);
        wr(`QPC_DIV_OFS, 32'h0);
        rc(`QPC_DIV_OFS, 32'h3);
        wr(`QPC_CMD_OFS, 32'h1);
        pulses = 0;
        enc_u.move(2'h1, 7);
        chk("pulses", pulses, 2);
        wr(`QPC_DIV_OFS, 32'h1);
    endtask

    task automatic t_clear();
        wr(`QPC_CTRL_OFS, 32'h1);
        wr(`QPC_POS_OFS, 32'h5);
        rc(`QPC_POS_OFS, 32'h5);
        wr(`QPC_CMD_OFS, 32'h1);
        rc(`QPC_CAP_OFS, 32'h5);
        enc_u.move(2'h1, 2);
        rc(`QPC_POS_OFS, 32'h2);
        wr(`QPC_SRC_OFS, 32'h1_0201);
        for (int s = 0; s < 3; s++) begin
            wr(`QPC_CTRL_OFS, 32'h1 | (s << 8));
            wr(`QPC_POS_OFS, 32'h9);
            clear_sources[0] <= 1'b1;
            idle(3);
            rc(`QPC_POS_OFS, (s == 1) ? 32'h9 : 32'h0);
            wr(`QPC_POS_OFS, 32'h7);
            clear_sources[0] <= 1'b0;
            idle(3);
            rc(`QPC_POS_OFS, (s == 0) ? 32'h7 : 32'h0);
        end
        rc(`QPC_CAP_OFS, 32'h7);
        wr(`QPC_CTRL_OFS, 32'h301);
        clear_sources[0] <= 1'b1;
        enc_u.move(2'h1, 2);
        rc(`QPC_POS_OFS, 32'h0);
        wr(`QPC_CTRL_OFS, 32'h401);
        enc_u.move(2'h1, 2);
        rc(`QPC_POS_OFS, 32'h2);
        clear_sources[0] <= 1'b0;
        idle(3);
        rc(`QPC_POS_OFS, 32'h0);
        wr(`QPC_SRC_OFS, 32'h201);
    endtask

    task automatic t_timeout();
        wr(`QPC_TMO_OFS, 32'h1);
        wr(`QPC_TMO_OFS, 32'h0);
        rc(`QPC_TMO_OFS, 32'h1);
        wr(`QPC_POS_OFS, `QPC_POS_MAX);
        enc_u.move(2'h1, 1);
        rc(`QPC_POS_OFS, `QPC_POS_MIN);
        chk("state", motion_state, QPC_LAST_STEP_INCREMENT);
        idle(100);
        chk("state", motion_state, QPC_NO_MOTION_TIMED_OUT);
        rc(`QPC_STAT_OFS, 32'h3);
    endtask

    initial begin
        idle(4);
        hresetn <= 1'b1;
        idle(1);
        t_reset();
        t_filtered();
        t_modes();
        t_divide();
        t_clear();
        t_timeout();
        give_verdict();
    end

    // Whole run needs well under a millisecond of simulated time
    initial begin
        #1000000;
        errors++;
        give_verdict();
    end
endmodule // qpc_bench
`default_nettype wire
